// ---- hw/burst_seq_counter.sv ----
`timescale 1ns/1ps
`default_nettype none

// Two-bit burst counter that produces the low address bits of a burst.
module burst_seq_counter (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // Control from the capture logic.
   input wire logic i_load,
   input wire logic [sram_ctrl_pkg::BURST_W-1:0] i_start,
   input wire logic i_advance,
   input wire sram_ctrl_pkg::burst_order_e i_order,
   // Current low address bits.
   output logic [sram_ctrl_pkg::BURST_W-1:0] o_low
);
   import sram_ctrl_pkg::*;

   // Start value, step count and the resulting low bits.
   typedef struct packed {
      logic [BURST_W-1:0] start;
      logic [BURST_W-1:0] cnt;
      logic [BURST_W-1:0] low;
   } cnt_state_s;

   cnt_state_s s_q; // Registered counter state.
   cnt_state_s s_d; // Next counter state.

   // A load restarts the sequence; an advance steps it, wrapping inside the group of four.
   always_comb begin
      s_d = s_q;
      if (i_load) begin
         s_d.start = i_start;
         s_d.cnt = BURST_RST;
      end else if (i_advance) begin
         s_d.cnt = s_q.cnt + 2'h1;
      end
      // Linear order adds the step, interleaved order flips address bits by it.
      if (i_order == BURST_LINEAR) begin
         s_d.low = s_d.start + s_d.cnt;
      end else begin
         s_d.low = s_d.start ^ s_d.cnt;
      end
   end

   // State register with constant reset values.
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         s_q <= '{start: BURST_RST, cnt: BURST_RST, low: BURST_RST};
      end else begin
         s_q <= s_d;
      end
   end

   // The low bits come straight from the register.
   assign o_low = s_q.low;

endmodule : burst_seq_counter

`default_nettype wire

// ---- hw/sram_addr_ctrl.sv ----
// Notes on behaviour
// - Capture address on strobe with chip enabled.
// - Captured low two bits load burst counter.
// - Byte lane written when select and enable low.
// - Global write writes all lanes regardless.
// - Advance low increments burst counter each edge.
// - Processor strobe ignored while chip enable one high.
// - Selected: enable one low, two high, three low.
// - Chip enables sampled only at address load.
// - Ball-grid variant treats enable three always active.
// - Output enable low drives pins, high floats.
// - First read after deselect keeps pins floating.
// - Both strobes low: processor strobe wins.
// - Strap low linear, high interleaved, held static.
// - Pins float during write data and deselect.
`timescale 1ns/1ps
`default_nettype none

// Control and address capture front end of a synchronous pipelined burst SRAM.
module sram_addr_ctrl #(
   parameter bit BALL_GRID = 1'b0 // Set for the package that has no third chip enable.
) (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // Address and strobes, all synchronous to the clock.
   input wire logic [sram_ctrl_pkg::ADDR_W-1:0] i_addr,
   input wire logic i_proc_addr_strobe_n,
   input wire logic i_ctrl_addr_strobe_n,
   input wire logic i_burst_advance_n,
   // Chip enables.
   input wire logic i_chip_en1_n,
   input wire logic i_chip_en2,
   input wire logic i_chip_en3_n,
   // Write controls.
   input wire logic i_global_write_n,
   input wire logic i_byte_write_en_n,
   input wire logic [sram_ctrl_pkg::LANES-1:0] i_byte_lane_sel_n,
   // Asynchronous output enable and the static burst-order strap.
   input wire logic i_out_en_n,
   input wire logic i_burst_mode,
   // Data pins, split into input, output and per-lane output enable.
   input wire logic [sram_ctrl_pkg::DATA_W-1:0] i_dq,
   output logic [sram_ctrl_pkg::DATA_W-1:0] o_dq,
   output logic [sram_ctrl_pkg::LANES-1:0] o_dq_oe,
   // Array side.
   input wire logic [sram_ctrl_pkg::DATA_W-1:0] i_rd_data,
   output logic [sram_ctrl_pkg::ADDR_W-1:0] o_addr,
   output logic o_selected,
   output logic o_wr_en,
   output logic [sram_ctrl_pkg::LANES-1:0] o_wr_lane_en,
   output logic [sram_ctrl_pkg::DATA_W-1:0] o_wr_data
);
   import sram_ctrl_pkg::*;

   // Whole module state in one record.
   typedef struct packed {
      logic [ADDR_W-1:0] addr;      // Captured external address.
      logic sel;                    // Selection fixed at the last address load.
      logic wr;                     // Current cycle writes the array.
      logic first_rd;               // First read clock after a deselected state.
      logic oe_s1;                  // Output enable synchroniser, first stage.
      logic oe_s2;                  // Output enable synchroniser, second stage.
      logic mode_s1;                // Strap synchroniser, first stage.
      logic mode_s2;                // Strap synchroniser, second stage.
      logic [1:0] mode_cnt;         // Settling count before the strap is frozen.
      logic mode_ok;                // Strap value has been frozen.
      burst_order_e order;          // Frozen burst order.
      logic [LANES-1:0] lane_en;    // Lanes written in the current cycle.
      logic [DATA_W-1:0] wr_data;   // Data captured from the pins.
      logic [DATA_W-1:0] rd_data;   // Read data driven onto the pins.
   } ctrl_state_s;

   ctrl_state_s s_q; // Registered state.
   ctrl_state_s s_d; // Next state.

   logic proc_load;            // Processor strobe recognised this edge.
   logic ctrl_load;            // Controller strobe recognised this edge.
   logic any_load;             // Some strobe loads a new external address.
   logic chip_hit;             // Chip enables decode to selected.
   logic write_req;            // Write controls ask for a write.
   logic [LANES-1:0] lane_req; // Lanes the write controls ask for.
   logic burst_step;           // Counter advances this edge.
   logic [BURST_W-1:0] burst_low; // Low address bits from the burst counter.

   // Strobe arbitration and chip select decode.
   always_comb begin
      // The processor strobe counts only while the first enable is low.
      proc_load = !i_proc_addr_strobe_n && !i_chip_en1_n;
      // With both strobes low and the first enable low the processor strobe takes the cycle.
      ctrl_load = !i_ctrl_addr_strobe_n && !proc_load;
      any_load = proc_load || ctrl_load;
      // The third enable is absent on the ball-grid part and reads as active.
      chip_hit = !i_chip_en1_n && i_chip_en2 && (BALL_GRID || !i_chip_en3_n);
   end

   // Write decode; a global write overrides byte selects and byte write enable.
   always_comb begin
      if (!i_global_write_n) begin
         lane_req = {LANES{1'b1}};
      end else if (!i_byte_write_en_n) begin
         lane_req = ~i_byte_lane_sel_n;
      end else begin
         lane_req = LANE_RST;
      end
      write_req = |lane_req;
   end

   // Advance only inside a selected burst and never on a load edge, where the load wins.
   assign burst_step = s_q.sel && !any_load && !i_burst_advance_n;

   // Next-state logic for the whole module.
   always_comb begin
      s_d = s_q;
      // Two flops ahead of any reader, since the output enable is asynchronous.
      s_d.oe_s1 = i_out_en_n;
      s_d.oe_s2 = s_q.oe_s1;
      // The strap is synchronised, allowed to settle, then frozen for good.
      s_d.mode_s1 = i_burst_mode;
      s_d.mode_s2 = s_q.mode_s1;
      if (!s_q.mode_ok) begin
         if (s_q.mode_cnt == STRAP_SETTLE) begin
            s_d.mode_ok = 1'b1;
            s_d.order = s_q.mode_s2 ? BURST_INTERLEAVED : BURST_LINEAR;
         end else begin
            s_d.mode_cnt = s_q.mode_cnt + 2'h1;
         end
      end
      s_d.first_rd = 1'b0;
      if (any_load) begin
         // Enables are looked at only here; the burst keeps what was seen now.
         s_d.sel = chip_hit;
         if (chip_hit) begin
            s_d.addr = i_addr;
         end
         // A processor-started cycle begins as a read; a controller start may write.
         s_d.wr = chip_hit && ctrl_load && write_req;
         s_d.lane_en = (chip_hit && ctrl_load) ? lane_req : LANE_RST;
         // Leaving the deselected state into a read masks the output enable once.
         s_d.first_rd = chip_hit && !s_d.wr && !s_q.sel;
      end else if (s_q.sel) begin
         // Continuation cycles take the write controls of this edge.
         s_d.wr = write_req;
         s_d.lane_en = lane_req;
      end else begin
         s_d.wr = 1'b0;
         s_d.lane_en = LANE_RST;
      end
      // Each lane takes its own nine pin bits, parity included, only when its lane writes.
      for (int unsigned i = 0; i < LANES; i++) begin
         if (s_d.wr && s_d.lane_en[i]) begin
            s_d.wr_data[i*LANE_W +: LANE_W] = i_dq[i*LANE_W +: LANE_W];
         end
      end
      // Read data is registered so the pins always show a flop output.
      s_d.rd_data = i_rd_data;
   end

   // State register; every field resets to a constant.
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         s_q <= '{addr: ADDR_RST, sel: 1'b0, wr: 1'b0, first_rd: 1'b0,
                  oe_s1: 1'b1, oe_s2: 1'b1, mode_s1: 1'b1, mode_s2: 1'b1,
                  mode_cnt: 2'h0, mode_ok: 1'b0, order: BURST_INTERLEAVED,
                  lane_en: LANE_RST, wr_data: DATA_RST, rd_data: DATA_RST};
      end else begin
         s_q <= s_d;
      end
   end

   // Burst counter seeded with the captured low bits.
   burst_seq_counter u_burst (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_load(any_load && chip_hit),
      .i_start(i_addr[BURST_W-1:0]),
      .i_advance(burst_step),
      .i_order(s_q.order),
      .o_low(burst_low)
   );

   // Pin drivers, one per lane so each lane has its own enable.
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         // Drive only in a selected read that is not the masked first clock.
         // The enable uses the synchronised level, so it lags the pin by two clocks.
         assign o_dq_oe[g] = s_q.sel && !s_q.wr && !s_q.first_rd && !s_q.oe_s2;
         assign o_dq[g*LANE_W +: LANE_W] = s_q.rd_data[g*LANE_W +: LANE_W];
      end
   endgenerate

   // Array-side outputs.
   assign o_addr = {s_q.addr[ADDR_W-1:BURST_W], burst_low};
   assign o_selected = s_q.sel;
   assign o_wr_en = s_q.wr;
   assign o_wr_lane_en = s_q.lane_en;
   assign o_wr_data = s_q.wr_data;

   // A selected load takes the whole address on the next edge.
   a_load_captures_addr: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (any_load && chip_hit) |=> (s_q.addr == $past(i_addr)))
      else $error("Address not captured on selected load.");

   // The counter starts from the captured low bits.
   a_counter_seeded: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (any_load && chip_hit) |=> (burst_low == $past(i_addr[BURST_W-1:0])))
      else $error("Burst counter not loaded from low address bits.");

   // Byte writes follow the selects exactly when the global write is off.
   a_byte_lane_map: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (s_q.sel && !any_load && i_global_write_n && !i_byte_write_en_n)
      |=> (o_wr_lane_en == ~$past(i_byte_lane_sel_n)))
      else $error("Written lanes differ from byte selects.");

   // A global write enables every lane whatever the byte controls say.
   a_global_all_lanes: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (s_q.sel && !any_load && !i_global_write_n) |=> (o_wr_en && o_wr_lane_en == 4'hf))
      else $error("Global write did not enable all lanes.");

   // In linear order an advance steps the low bits by one, wrapping.
   a_linear_advance: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (burst_step && s_q.order == BURST_LINEAR && s_d.order == BURST_LINEAR)
      |=> (burst_low == $past(burst_low) + 2'h1))
      else $error("Linear burst did not advance by one.");

   // A processor strobe with the first enable high changes nothing by itself.
   a_proc_strobe_ignored: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (!i_proc_addr_strobe_n && i_chip_en1_n && i_ctrl_addr_strobe_n)
      |=> ($stable(s_q.addr) && $stable(s_q.sel)))
      else $error("Ignored processor strobe changed state.");

   // Selection after a load equals the decode of the enables at that edge.
   a_select_decode: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      any_load |=> (o_selected == $past(!i_chip_en1_n && i_chip_en2
                    && (BALL_GRID || !i_chip_en3_n))))
      else $error("Selection does not match chip enable decode.");

   // Without a load the selection holds through the burst.
   a_select_held: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      !any_load |=> $stable(o_selected))
      else $error("Selection changed without an address load.");

   // Both strobes low with the chip enabled starts a read, never a write.
   a_proc_priority: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (!i_proc_addr_strobe_n && !i_ctrl_addr_strobe_n && !i_chip_en1_n && !i_global_write_n)
      |=> !o_wr_en)
      else $error("Controller strobe acted despite processor strobe.");

   // The first read clock out of deselect never drives the pins.
   a_first_read_float: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (any_load && chip_hit && !s_q.sel && !(ctrl_load && write_req)) |=> (o_dq_oe == 4'h0))
      else $error("Pins driven in first read clock after deselect.");

   // Writes and deselection keep every lane floating.
   a_write_float: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (o_wr_en || !o_selected) |-> (o_dq_oe == 4'h0))
      else $error("Pins driven during write or deselect.");

   // A steady low output enable in a selected read drives the pins after two clocks.
   a_oe_drives: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (!i_out_en_n [*2] ##1 (!i_out_en_n && s_q.sel && !s_q.wr && !s_q.first_rd))
      |-> (o_dq_oe == 4'hf))
      else $error("Output enable low did not drive the pins.");

endmodule : sram_addr_ctrl

`default_nettype wire

// ---- include/sram_ctrl_pkg.sv ----
`default_nettype none

// Shared widths, reset values and sequencing constants of the SRAM control front end.
package sram_ctrl_pkg;

   // Byte lanes on the data bus and the width of one lane, parity bit included.
   localparam int unsigned LANES = 4;
   localparam int unsigned LANE_W = 9;
   localparam int unsigned DATA_W = LANES * LANE_W;

   // Address width of the one-word-per-location array.
   localparam int unsigned ADDR_W = 20;

   // Width of the burst counter and of the low address field it replaces.
   localparam int unsigned BURST_W = 2;

   // Position of the parity bit inside one lane.
   localparam int unsigned PARITY_POS = 8;

   // Reset values of the control state.
   localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
   localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
   localparam logic [LANES-1:0] LANE_RST = 4'h0;
   localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;

   // Settling count of the strap synchroniser before its value is frozen.
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

   // Burst orders chosen by the static strap.
   typedef enum logic {
      BURST_LINEAR,
      BURST_INTERLEAVED
   } burst_order_e;

endpackage : sram_ctrl_pkg

`default_nettype wire

// ---- test/sram_array_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Behavioural array behind the control front end.
module sram_array_model (
   // Clock.
   input wire logic i_core_clk,
   // Access from the control front end.
   input wire logic [sram_ctrl_pkg::ADDR_W-1:0] i_addr,
   input wire logic i_wr_en,
   input wire logic [sram_ctrl_pkg::LANES-1:0] i_wr_lane_en,
   input wire logic [sram_ctrl_pkg::DATA_W-1:0] i_wr_data,
   // Read data of the current address.
   output logic [sram_ctrl_pkg::DATA_W-1:0] o_rd_data
);
   import sram_ctrl_pkg::*;

   // Sixteen words keep the model cheap; upper address bits alias onto them.
   logic [DATA_W-1:0] mem [16];

   // Each word starts as its index above a fixed filler, so each of the sixteen words reads differently.
   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = {4'(i), 32'h5a5a5a5a};
      end
   end

   // Flow-through read; the front end registers it on the next edge.
   assign o_rd_data = mem[i_addr[3:0]];

   // A write lands at the edge after the front end flags it, all enabled lanes at once.
   always @(posedge i_core_clk) begin
      if (i_wr_en) begin
         for (int l = 0; l < LANES; l++) begin
            if (i_wr_lane_en[l]) begin
               mem[i_addr[3:0]][l*LANE_W +: LANE_W] <= i_wr_data[l*LANE_W +: LANE_W];
            end
         end
      end
   end
endmodule : sram_array_model

`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench for the SRAM control front end with a small array behind it.
module tb;
   import sram_ctrl_pkg::*;

   // Clock and reset; reset starts asserted.
   logic i_core_clk = 1'b0, i_nrst = 1'b0;
   // Strobes, advance and write controls start inactive; output enable starts on.
   logic i_proc_addr_strobe_n = 1'b1, i_ctrl_addr_strobe_n = 1'b1, i_burst_advance_n = 1'b1;
   logic i_global_write_n = 1'b1, i_byte_write_en_n = 1'b1, i_out_en_n = 1'b0;
   // Chip enables start deselected and the strap starts linear.
   logic i_chip_en1_n = 1'b1, i_chip_en2 = 1'b0, i_chip_en3_n = 1'b1, i_burst_mode = 1'b0;
   logic [LANES-1:0] i_byte_lane_sel_n = 4'hf;
   logic [ADDR_W-1:0] i_addr = 20'h00000;
   logic [DATA_W-1:0] i_dq = 36'h000000000;
   // Device outputs and the array's read data.
   logic [DATA_W-1:0] i_rd_data, o_dq, o_wr_data;
   logic [LANES-1:0] o_dq_oe, o_wr_lane_en;
   logic [ADDR_W-1:0] o_addr;
   logic o_selected, o_wr_en, bg_selected;
   // Counters of mismatches and comparisons.
   int n_fail = 0, checked = 0;

   // Free-running 40 MHz clock.
   initial begin
      forever #12.5 i_core_clk = ~i_core_clk;
   end

   // Device with the third chip enable in use.
   sram_addr_ctrl #(.BALL_GRID(1'b0)) sram_addr_ctrl_inst (
      .i_core_clk, .i_nrst, .i_addr, .i_proc_addr_strobe_n, .i_ctrl_addr_strobe_n,
      .i_burst_advance_n, .i_chip_en1_n, .i_chip_en2, .i_chip_en3_n, .i_global_write_n,
      .i_byte_write_en_n, .i_byte_lane_sel_n, .i_out_en_n, .i_burst_mode, .i_dq, .o_dq,
      .o_dq_oe, .i_rd_data, .o_addr, .o_selected, .o_wr_en, .o_wr_lane_en, .o_wr_data);

   // Package variant without the third chip enable; only its selection is watched.
   sram_addr_ctrl #(.BALL_GRID(1'b1)) sram_addr_ctrl_inst_bg (
      .i_core_clk, .i_nrst, .i_addr, .i_proc_addr_strobe_n, .i_ctrl_addr_strobe_n,
      .i_burst_advance_n, .i_chip_en1_n, .i_chip_en2, .i_chip_en3_n, .i_global_write_n,
      .i_byte_write_en_n, .i_byte_lane_sel_n, .i_out_en_n, .i_burst_mode, .i_dq, .o_dq(),
      .o_dq_oe(), .i_rd_data, .o_addr(), .o_selected(bg_selected), .o_wr_en(),
      .o_wr_lane_en(), .o_wr_data());

   // Array on the far side of the main device.
   sram_array_model sram_array_model_inst (.i_core_clk, .i_addr(o_addr), .i_wr_en(o_wr_en),
      .i_wr_lane_en(o_wr_lane_en), .i_wr_data(o_wr_data), .o_rd_data(i_rd_data));

   // Prints the verdict and ends the run.
   task automatic stop_test();
      if (n_fail == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test

   // Compares one value; case inequality keeps an unknown from passing.
   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string s);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, s, got, exp);
      end
   endtask : chk

   // Returns strobes, advance and write controls to their inactive levels.
   task automatic idle();
      {i_proc_addr_strobe_n, i_ctrl_addr_strobe_n, i_burst_advance_n} <= 3'h7;
      {i_global_write_n, i_byte_write_en_n, i_byte_lane_sel_n} <= 6'h3f;
   endtask : idle

   // Resets with the strap at the given level; the strap is frozen a fixed few clocks after release, held still or not.
   task automatic do_reset(input logic mode);
      @(posedge i_core_clk);
      i_nrst <= 1'b0;
      i_burst_mode <= mode;
      idle();
      repeat (5) @(posedge i_core_clk);
      @(negedge i_core_clk);
      chk({o_addr, o_selected, o_wr_en, o_dq_oe}, '0, "reset values");
      @(posedge i_core_clk);
      i_nrst <= 1'b1;
      repeat (4) @(posedge i_core_clk);
   endtask : do_reset

   // Presents one load for one cycle; stb is {processor, controller} strobe, en {en3, en2, en1}.
   task automatic load(input logic [1:0] stb, input logic [ADDR_W-1:0] a, input logic [2:0] en,
         input logic [5:0] wc = 6'h3f, input logic [DATA_W-1:0] d = 36'h000000000);
      @(posedge i_core_clk);
      {i_proc_addr_strobe_n, i_ctrl_addr_strobe_n} <= stb;
      {i_chip_en3_n, i_chip_en2, i_chip_en1_n} <= en;
      {i_global_write_n, i_byte_write_en_n, i_byte_lane_sel_n} <= wc;
      i_addr <= a;
      i_dq <= d;
      @(posedge i_core_clk);
      idle();
      @(negedge i_core_clk);
   endtask : load

   // Holds advance for one edge when asked, then releases it.
   task automatic burst_advance_n(input logic on);
      @(posedge i_core_clk);
      i_burst_advance_n <= !on;
      @(posedge i_core_clk);
      i_burst_advance_n <= 1'b1;
      @(negedge i_core_clk);
   endtask : burst_advance_n

   // Presents write controls and data for one continuation edge of a selected burst.
   task automatic cont(input logic [5:0] wc, input logic [DATA_W-1:0] d);
      @(posedge i_core_clk);
      {i_global_write_n, i_byte_write_en_n, i_byte_lane_sel_n} <= wc;
      i_dq <= d;
      @(posedge i_core_clk);
      idle();
      @(negedge i_core_clk);
   endtask : cont

   // Read burst from a deselected state, in the order that the strap selects.
   task automatic t_burst(input logic mode);
      logic [1:0] low, prev;
      do_reset(mode);
      load(2'b01, 20'h12341, 3'b010);
      chk(o_selected, 1'b1, "selected after load");
      chk(o_addr, 20'h12341, "captured address");
      chk(o_dq_oe, 4'h0, "first read masked");
      low = 2'h1;
      for (int k = 1; k < 4; k++) begin
         prev = low;
         low = mode ? (2'h1 ^ 2'(k)) : (2'h1 + 2'(k));
         burst_advance_n(1'b1);
         chk(o_addr, {18'h048d0, low}, "burst address");
         chk(o_dq, {2'h0, prev, 32'h5a5a5a5a}, "read data");
         chk(o_dq_oe, 4'hf, "pins drive read data");
      end
      burst_advance_n(1'b0);
      chk(o_addr, {18'h048d0, low}, "address holds without advance");
   endtask : t_burst

   // Output enable high floats the pins, low drives them again after its lag.
   task automatic t_oe();
      @(posedge i_core_clk);
      i_out_en_n <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      @(negedge i_core_clk);
      chk(o_dq_oe, 4'h0, "pins float with enable high");
      @(posedge i_core_clk);
      i_out_en_n <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      @(negedge i_core_clk);
      chk(o_dq_oe, 4'hf, "pins drive with enable low");
   endtask : t_oe

   // Processor strobe with enable one high, a burst after the enables drop, and both strobes.
   task automatic t_strobes();
      load(2'b10, 20'h0bcd6, 3'b010);
      load(2'b01, 20'h77777, 3'b011);
      chk(o_addr, 20'h0bcd6, "processor strobe ignored");
      burst_advance_n(1'b1);
      chk(o_selected, 1'b1, "selection kept in burst");
      chk(o_addr, 20'h0bcd7, "advance after enables changed");
      load(2'b00, 20'h3c3c8, 3'b010, 6'h00);
      chk(o_wr_en, 1'b0, "processor strobe wins as read");
      chk(o_addr, 20'h3c3c8, "processor strobe address");
   endtask : t_strobes

   // Every chip enable combination, loaded by the controller strobe.
   task automatic t_decode();
      logic [ADDR_W-1:0] a, exp_a;
      load(2'b10, 20'h44440, 3'b010);
      exp_a = 20'h44440;
      for (int i = 0; i < 8; i++) begin
         a = 20'h50000 + 20'(i);
         exp_a = (i == 2) ? a : exp_a;
         load(2'b10, a, 3'(i));
         chk(o_selected, i == 2, "selection decode");
         chk(bg_selected, (i % 4) == 2, "decode without third enable");
         chk(o_addr, exp_a, "address kept when deselected");
         if (i != 2) chk(o_dq_oe, 4'h0, "pins float when deselected");
      end
   endtask : t_decode

   // Byte writes per lane, a refused byte write, a global write and its read-back.
   task automatic t_write();
      logic [5:0] wc [6] = '{6'h2e, 6'h2d, 6'h2b, 6'h27, 6'h30, 6'h1f};
      logic [3:0] ln [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'hf};
      logic [DATA_W-1:0] d, m;
      for (int j = 0; j < 6; j++) begin
         d = 36'h9a5b4c3d2 + 36'h102030405 * 36'(j);
         for (int l = 0; l < 4; l++) m[l*9 +: 9] = {9{ln[j][l]}};
         load(2'b10, 20'h55550 + 20'(j), 3'b010, wc[j], d);
         chk(o_wr_lane_en, ln[j], "lanes written");
         chk(o_wr_en, |ln[j], "write cycle");
         chk(o_wr_data & m, d & m, "lane data and parity");
         if (ln[j] != 4'h0) chk(o_dq_oe, 4'h0, "pins float while writing");
      end
      load(2'b01, 20'h55555, 3'b010);
      chk(o_dq, d, "global write read back");
      // Writes inside a running burst take the controls of each edge.
      cont(6'h2b, 36'h123456789);
      chk(o_wr_lane_en, 4'h4, "continuation byte write lanes");
      chk(o_wr_data[18 +: 9], 9'h0d1, "continuation lane data");
      cont(6'h1f, 36'hfedcba987);
      chk({o_wr_en, o_wr_lane_en}, 5'h1f, "continuation global write");
      chk(o_wr_data, 36'hfedcba987, "continuation global data");
   endtask : t_write

   // A hang is cut short well past the length of the whole run.
   initial begin
      repeat (2000) @(posedge i_core_clk);
      n_fail++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      stop_test();
   end

   // Main sequence.
   initial begin
      t_burst(1'b0);
      t_oe();
      t_burst(1'b1);
      t_strobes();
      t_decode();
      t_write();
      stop_test();
   end
endmodule : tb

`default_nettype wire
